/* core/asw_ctrl.sv */
// controller that drives write cycles and power-down on an async 512k x 16 sram
// Overview of operation
// (RQ1) a write is the overlap of selects, one lane, and a low write strobe
// (RQ2) strobe falls no later than selects, so the memory keeps data tri-stated
// (RQ3) address stands at least the setup time before the strobe rises
// (RQ4) each used lane enable is active the setup time before the write ends
// (RQ5) both chip selects are active the setup time before the write ends
// (RQ6) memory releases data within the disable time after strobe falls
// (RQ7) memory does not drive data sooner than 5 ns after strobe rises
// (RQ8) memory tri-states data within the disable time after out enable rises
// (RQ9) controller never drives data while the memory may be driving
// (RQ10) lane power-down holds chip selects at fixed levels
// (RQ11) select power-down holds the high select fixed
// (RQ12) memory is deselected before supply drops, setup zero; a write under way when supply_ok falls still runs to its end
// (RQ13) memory stays deselected 5 ms after supply returns before any access
// (RQ14) write data is valid before and held until the write conditions end
// (RQ15) write ends by the strobe rising first, which ends the cycle
`timescale 1ns/1ps
module asw_ctrl #(
  parameter int REC_CYCLES = asw_pkg::REC_PD_CYCLES
) (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  reset,
  // user request
  input  wire logic                  req_valid,
  input  wire asw_pkg::asw_req_type  req,
  output logic                       req_ready,
  // power control
  input  wire logic                  pd_request,
  input  wire logic                  supply_ok,
  output logic                       pd_active,
  // memory pins
  output asw_pkg::asw_pins_type      pins,
  output logic [15:0]                dq_out,
  output logic                       dq_oe,
  input  wire logic [15:0]           dq_in
);
  typedef enum logic [2:0] {
    ST_RECOVER, ST_IDLE, ST_TURN, ST_STROBE, ST_SETUP, ST_HOLD, ST_POWERDOWN
  } asw_state_type;

  asw_state_type state;
  asw_state_type next_state;
  logic [7:0]    cnt;
  logic          rec_load;
  logic          rec_done;
  logic          active;
  logic          rec_start;
  logic [1:0]    write_lanes;

  asw_delay #(.WIDTH(32)) u_rec (
    .clock (clock),
    .reset (reset),
    .load  (rec_load),
    .count (32'(REC_CYCLES)),
    .done  (rec_done)
  );

  // first cycle out of reset reloads recovery, as after a supply return
  always_ff @(posedge clock) begin
    if (reset) rec_start <= 1'b1;
    else       rec_start <= 1'b0;
  end

  // recovery restarts whenever supply is absent, in power-down, or after reset
  assign rec_load = !supply_ok || (state == ST_POWERDOWN) || rec_start; // RQ13

  always_comb begin
    next_state = state;
    unique case (state)
      ST_RECOVER:   if (rec_done && supply_ok) next_state = ST_IDLE; // RQ13
      ST_IDLE: begin
        if (pd_request || !supply_ok) next_state = ST_POWERDOWN; // RQ12
        else if (req_valid && req.lanes != 2'h0) next_state = ST_TURN;
      end
      ST_TURN:      if (cnt == 8'h0) next_state = ST_STROBE;
      ST_STROBE:    next_state = ST_SETUP;
      ST_SETUP:     if (cnt == 8'h0) next_state = ST_HOLD;
      ST_HOLD:      next_state = ST_IDLE;
      ST_POWERDOWN: if (!pd_request && supply_ok) next_state = ST_RECOVER;
      default:      next_state = ST_RECOVER;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) state <= ST_RECOVER;
    else       state <= next_state;
  end

  // one counter serves turnaround and setup waits
  always_ff @(posedge clock) begin
    if (reset) begin
      cnt <= 8'h0;
    end else if (state == ST_IDLE) begin
      cnt <= 8'(asw_pkg::TURN_CYCLES - 1); // RQ6
    end else if (state == ST_STROBE) begin
      cnt <= 8'(asw_pkg::SETUP_CYCLES - 2); // RQ3
    end else if (cnt != 8'h0) begin
      cnt <= cnt - 8'h1;
    end
  end

  assign req_ready = (state == ST_IDLE) && !pd_request && supply_ok;
  assign pd_active = (state == ST_POWERDOWN);
  assign active    = (state == ST_STROBE) || (state == ST_SETUP);

  // address and data latched once per write, held through hold cycle
  always_ff @(posedge clock) begin
    if (reset) begin
      pins.addr   <= '0;
      dq_out      <= 16'h0;
      write_lanes <= 2'h0;
    end else if (req_valid && req_ready && req.lanes != 2'h0) begin
      pins.addr   <= req.addr; // RQ3
      dq_out      <= req.data; // RQ14
      // lanes kept too: the request may move on once taken
      write_lanes <= req.lanes; // RQ4
    end
  end

  // output enable stays high always, so the memory never drives
  always_ff @(posedge clock) begin
    if (reset) begin
      pins.out_en_n <= 1'b1; // RQ8
      dq_oe         <= 1'b0;
    end else begin
      pins.out_en_n <= 1'b1;
      dq_oe         <= (next_state == ST_STROBE) || (next_state == ST_SETUP) ||
                       (next_state == ST_HOLD); // RQ9 RQ14
    end
  end

  // strobe falls together with selects and lanes, rises first to end the write
  always_ff @(posedge clock) begin
    if (reset) begin
      pins.write_strobe_n <= 1'b1;
      pins.chip_sel_n     <= 1'b1;
      pins.chip_sel_hi    <= 1'b0;
      pins.lane_lo_en_n   <= 1'b1;
      pins.lane_hi_en_n   <= 1'b1;
    end else begin
      pins.write_strobe_n <= !((next_state == ST_STROBE) || (next_state == ST_SETUP)); // RQ2 RQ15
      // selects remain valid one cycle after strobe rises as hold margin
      pins.chip_sel_n     <= !((next_state == ST_STROBE) || (next_state == ST_SETUP) ||
                               (next_state == ST_HOLD)); // RQ5 RQ11
      // high select held high: writes pass, and either power-down mode sees it fixed
      pins.chip_sel_hi    <= 1'b1; // RQ1 RQ10 RQ11
      if (next_state == ST_STROBE) begin
        pins.lane_lo_en_n <= !write_lanes[0]; // RQ4
        pins.lane_hi_en_n <= !write_lanes[1];
      end else if (next_state == ST_IDLE || next_state == ST_POWERDOWN ||
                   next_state == ST_RECOVER) begin
        pins.lane_lo_en_n <= 1'b1;
        pins.lane_hi_en_n <= 1'b1;
      end
    end
  end

  sequence s_write_start;
    $fell(pins.write_strobe_n);
  endsequence

  sequence s_write_low;
    !pins.write_strobe_n [*4];
  endsequence

  sequence s_write_end;
    pins.write_strobe_n && !pins.chip_sel_n ##1
      pins.chip_sel_n && pins.lane_lo_en_n && pins.lane_hi_en_n && !dq_oe;
  endsequence

  chk_strobe_width: assert property (@(posedge clock) disable iff (reset)
    s_write_start |-> s_write_low ##1 pins.write_strobe_n) // RQ3
    else $error("write strobe not held for setup time");

  chk_select_overlap: assert property (@(posedge clock) disable iff (reset)
    !pins.write_strobe_n |-> !pins.chip_sel_n && pins.chip_sel_hi && dq_oe &&
      !(pins.lane_lo_en_n && pins.lane_hi_en_n)) // RQ1
    else $error("strobe low without a complete write overlap");

  chk_strobe_first: assert property (@(posedge clock) disable iff (reset)
    $fell(pins.chip_sel_n) |-> $fell(pins.write_strobe_n)) // RQ2
    else $error("select fell before strobe");

  chk_lane_setup: assert property (@(posedge clock) disable iff (reset)
    $rose(pins.write_strobe_n) |-> $past(!(pins.lane_lo_en_n && pins.lane_hi_en_n), 4)) // RQ4
    else $error("lane enable not active for setup time");

  chk_select_setup: assert property (@(posedge clock) disable iff (reset)
    $rose(pins.write_strobe_n) |-> $past(!pins.chip_sel_n, 4) && !pins.chip_sel_n) // RQ5
    else $error("chip select not active for setup time");

  chk_data_hold: assert property (@(posedge clock) disable iff (reset)
    $rose(pins.write_strobe_n) |-> dq_oe && $stable(dq_out) ##1 !dq_oe) // RQ14
    else $error("write data not held past strobe");

  chk_no_contention: assert property (@(posedge clock) disable iff (reset)
    dq_oe |-> pins.out_en_n) // RQ9
    else $error("controller drives data while memory output enabled");

  chk_pd_deselect: assert property (@(posedge clock) disable iff (reset)
    pd_active |-> pins.chip_sel_n && pins.chip_sel_hi && pins.write_strobe_n) // RQ12
    else $error("memory not deselected in power-down");

  chk_recover_idle: assert property (@(posedge clock) disable iff (reset)
    $fell(pd_active) |-> !req_ready [*8]) // RQ13
    else $error("access allowed before recovery");

  chk_strobe_state: assert property (@(posedge clock) disable iff (reset)
    active == !pins.write_strobe_n) // RQ15
    else $error("strobe level disagrees with write state");

  chk_write_stable: assert property (@(posedge clock) disable iff (reset)
    !pins.write_strobe_n && !$past(pins.write_strobe_n) |->
      $stable({pins.addr, dq_out, pins.lane_lo_en_n, pins.lane_hi_en_n})) // RQ3 RQ4 RQ14
    else $error("address, data or lanes moved during the write");

  chk_write_close: assert property (@(posedge clock) disable iff (reset)
    $rose(pins.write_strobe_n) |-> s_write_end) // RQ15
    else $error("write not closed by strobe then selects");

  chk_hi_fixed: assert property (@(posedge clock) disable iff (reset)
    pd_active |-> pins.chip_sel_hi && $stable(pins.chip_sel_hi)) // RQ10 RQ11
    else $error("high select not fixed in power-down");

  chk_pd_quiet: assert property (@(posedge clock) disable iff (reset)
    pd_active |-> !dq_oe && pins.lane_lo_en_n && pins.lane_hi_en_n) // RQ10 RQ12
    else $error("lanes or data driven in power-down");

  chk_reset_recover: assert property (@(posedge clock) disable iff (reset)
    rec_start |=> !req_ready [*8]) // RQ13
    else $error("access allowed before recovery after reset");
endmodule

/* core/asw_delay.sv */
// down-counter that raises done after a loaded count of cycles and holds it until the next load
`timescale 1ns/1ps
module asw_delay #(
  parameter int WIDTH = 24
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             reset,
  // control
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] count,
  output logic                  done
);
  logic [WIDTH-1:0] remain;

  always_ff @(posedge clock) begin
    if (reset) begin
      remain <= '0;
    end else if (load) begin
      remain <= count;
    end else if (remain != '0) begin
      remain <= remain - 1'b1;
    end
  end

  assign done = (remain == '0) && !load;
endmodule

/* core/asw_pkg.sv */
// package: constants and carriers for the async sram write and power-down controller
package asw_pkg;
  localparam int  CLOCK_MHZ        = 50;
  localparam int  CLOCK_PERIOD_NS  = 20;
  // write timing, slowest speed grade
  localparam int  SETUP_NS         = 70;
  localparam int  DATA_SETUP_NS    = 45;
  localparam int  OUT_DISABLE_NS   = 30;
  localparam int  OUT_ENABLE_NS    = 5;
  localparam int  REC_PD_MS        = 5;
  localparam int  SETUP_CYCLES     = (SETUP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int  TURN_CYCLES      = (OUT_DISABLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int  ENABLE_CYCLES    = (OUT_ENABLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int  REC_PD_CYCLES    = REC_PD_MS * 1000 * CLOCK_MHZ;
  localparam int  ADDR_WIDTH       = 19;
  localparam int  DATA_WIDTH       = 16;

  typedef struct packed {
    logic [ADDR_WIDTH-1:0] addr;
    logic [DATA_WIDTH-1:0] data;
    logic [1:0]            lanes;
  } asw_req_type;

  typedef struct packed {
    logic                  chip_sel_n;
    logic                  chip_sel_hi;
    logic                  lane_lo_en_n;
    logic                  lane_hi_en_n;
    logic                  write_strobe_n;
    logic                  out_en_n;
    logic [ADDR_WIDTH-1:0] addr;
  } asw_pins_type;
endpackage

/* tb/asw_sram.sv */
// sram partner: byte-lane write capture, read drive, contention count
`timescale 1ns/1ps
module asw_sram (
  // memory pins
  input  wire asw_pkg::asw_pins_type pins,
  input  wire logic [15:0]           dq_out,
  input  wire logic                  dq_oe,
  output logic [15:0]                dq_in
);
  logic [15:0] mem [int];
  logic [36:0] lat = '0;
  logic        wr;
  logic        oe = 1'b0;
  int          clash = 0;
  assign wr = !pins.chip_sel_n && pins.chip_sel_hi && !pins.write_strobe_n
    && !(pins.lane_lo_en_n && pins.lane_hi_en_n);
  always @* if (wr) lat = {pins.addr, dq_out, ~pins.lane_hi_en_n, ~pins.lane_lo_en_n};
  // capture when the overlap ends, whichever pin ends it
  always @(negedge wr) begin
    if (!mem.exists(lat[36:18])) mem[lat[36:18]] = 16'h0000;
    mem[lat[36:18]] = {lat[1] ? lat[17:10] : mem[lat[36:18]][15:8],
      lat[0] ? lat[9:2] : mem[lat[36:18]][7:0]};
  end
  // a strobe that falls first never lets the outputs turn on
  always @(pins) if (pins.write_strobe_n && !pins.out_en_n && !pins.chip_sel_n
    && pins.chip_sel_hi) oe <= #5 1'b1; else oe <= #20 1'b0;
  always @(posedge (oe && dq_oe)) clash++;
  // released bus shows the inverse of the last write, not a stale copy
  assign dq_in = dq_oe ? dq_out : oe ? mem[pins.addr] : ~lat[17:2];
endmodule

/* tb/tb.sv */
// bench: random and corner writes, recovery, power-down and supply loss
`timescale 1ns/1ps
module tb;
  localparam int REC = 20;
  logic                  clock;
  logic                  reset;
  logic                  req_valid;
  asw_pkg::asw_req_type  req;
  asw_pkg::asw_req_type  taken = '0;
  logic                  req_ready;
  logic                  pd_request;
  logic                  supply_ok;
  logic                  pd_active;
  asw_pkg::asw_pins_type pins;
  logic [15:0]           dq_out;
  logic                  dq_oe;
  logic [15:0]           dq_in;
  logic [15:0]           shadow [int];
  logic [15:0]           seed = 16'h0005;
  int                    fails = 0;
  int                    compares = 0;
  int                    cycles = 0;
  int                    run = 0;
  int                    c;
  asw_ctrl #(.REC_CYCLES(REC)) i_dut (.clock(clock), .reset(reset), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .pd_request(pd_request), .supply_ok(supply_ok),
    .pd_active(pd_active), .pins(pins), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
  asw_sram i_mem (.pins(pins), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // request held until the edge that takes it; valid stays up for back-to-back
  task automatic wr(input logic [18:0] a, input logic [15:0] d, input logic [1:0] l);
    req <= '{addr: a, data: d, lanes: l};
    req_valid <= 1'b1;
    @(negedge clock);
    for (int k = 0; k < 40 && req_ready !== 1'b1; k++) @(negedge clock);
    @(posedge clock);
    if (l != 2'h0) taken = '{addr: a, data: d, lanes: l};
    if (l != 2'h0 && !shadow.exists(a)) shadow[a] = 16'h0000;
    if (l != 2'h0) shadow[a] = {l[1] ? d[15:8] : shadow[a][15:8], l[0] ? d[7:0] : shadow[a][7:0]};
  endtask
  task automatic recover(output int n);
    n = 0;
    while (n < 200 && req_ready !== 1'b1) begin
      @(posedge clock);
      n++;
      #1;
    end
  endtask
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      end_sim();
    end
  end
  // write phase watch: selects, lanes, address and data stand for the whole low strobe
  always @(negedge clock) begin
    if (pins.write_strobe_n === 1'b0) begin
      run++;
      chk({pins.chip_sel_n, pins.chip_sel_hi, dq_oe}, 3'h3);
      chk({pins.addr, dq_out, ~pins.lane_hi_en_n, ~pins.lane_lo_en_n}, taken);
    end else if (run != 0) begin
      chk(run, asw_pkg::SETUP_CYCLES);
      run = 0;
    end
  end
  initial begin
    reset = 1'b1;
    req_valid = 1'b0;
    req = '0;
    pd_request = 1'b0;
    supply_ok = 1'b1;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    #1 chk({pins.write_strobe_n, pins.chip_sel_n, pins.out_en_n, dq_oe}, 4'he);
    recover(c);
    // first edge after release reloads the count, then REC + 1 edges
    chk(c, REC + 2);
    $display("test recovery done");
    @(posedge clock);
    wr(19'h00000, 16'ha55a, 2'h3);
    wr(19'h7ffff, 16'h1234, 2'h1);
    wr(19'h7ffff, 16'hbeef, 2'h2);
    wr(19'h00000, 16'hffff, 2'h0);
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      wr({15'h0000, seed[3:0]}, lfsr(seed), seed[5:4]);
    end
    req_valid <= 1'b0;
    repeat (10) @(posedge clock);
    foreach (shadow[a]) chk(i_mem.mem[a], shadow[a]);
    $display("test writes done");
    pd_request <= 1'b1;
    repeat (2) @(posedge clock);
    #1 chk({pd_active, req_ready, pins.chip_sel_n, pins.write_strobe_n, pins.chip_sel_hi}, 5'h17);
    pd_request <= 1'b0;
    recover(c);
    chk(c >= REC && c <= REC + 2, 1'b1);
    supply_ok <= 1'b0;
    repeat (2) @(posedge clock);
    #1 chk({pd_active, req_ready, pins.chip_sel_n}, 3'h5);
    supply_ok <= 1'b1;
    recover(c);
    chk(c >= REC && c <= REC + 2, 1'b1);
    chk(i_mem.clash, 0);
    $display("test power-down done");
    end_sim();
  end
endmodule
